// >>> logic/cmre_core.sv
// Execution unit for store, indirect store, no-op, prescaler load, software reset and return from interrupt.
// Assumes the decoder presents one operation per cycle with opValid, and holds it off while opReady is low.
`default_nettype none
module cmre_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Operation request
  input wire logic opValid,
  input wire logic [2:0] opCode,
  input wire logic [cmre_pkg::FADDR_W-1:0] fileAddr,
  input wire logic ptrSel,
  input wire logic [1:0] pointerUpdateMode,
  input wire logic [cmre_pkg::OFS_W-1:0] relOffset,
  // Accumulator load from the rest of the core
  input wire logic accLoad,
  input wire logic [cmre_pkg::DATA_W-1:0] accIn,
  // Stack push from call or interrupt entry
  input wire logic stackPush,
  input wire logic [cmre_pkg::PC_W-1:0] pushAddr,
  // Flow control
  output logic opReady,
  // Data memory write port
  output logic memWrite,
  output logic [cmre_pkg::PTR_W-1:0] memAddr,
  output logic [cmre_pkg::DATA_W-1:0] memData,
  // Visible state
  output logic [cmre_pkg::PTR_W-1:0] indirectPointer0,
  output logic [cmre_pkg::PTR_W-1:0] indirectPointer1,
  output logic [cmre_pkg::DATA_W-1:0] prescalerConfig,
  output logic [cmre_pkg::DATA_W-1:0] irqControlReg,
  output logic [cmre_pkg::PC_W-1:0] programCounter,
  output logic [cmre_pkg::PC_W-1:0] stackTopEntry,
  output logic softResetIndicator,
  output logic [2:0] statusFlags,
  output logic deviceReset
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [cmre_pkg::DATA_W-1:0] acc, next_acc;
  logic [cmre_pkg::PTR_W-1:0] ptr [2];
  logic [cmre_pkg::PTR_W-1:0] next_ptr [2];
  logic [cmre_pkg::PC_W-1:0] stack [cmre_pkg::STACK_DEPTH];
  logic [cmre_pkg::SP_W-1:0] sp, next_sp;
  logic [cmre_pkg::PC_W-1:0] next_pc, next_pushSlot;
  logic next_memWrite, next_opReady, next_ri, next_devRst, pushEn;
  logic [cmre_pkg::PTR_W-1:0] next_memAddr;
  logic [cmre_pkg::DATA_W-1:0] next_memData, next_presc, next_irq;
  logic [cmre_pkg::PTR_W-1:0] effAddr, ptrUpd;
  cmre_pkg::cmre_state_t state, next_state;
  logic softReq;
  logic [1:0] retCount, next_retCount;

  cmre_ptr_unit ptrUnit (
    .ptrIn(ptr[ptrSel]),
    .updateMode(pointerUpdateMode),
    .relative(opCode == cmre_pkg::OP_STORE_REL),
    .offset(relOffset),
    .effAddr(effAddr),
    .ptrOut(ptrUpd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // The software reset acts as one more reset source for everything except its own indicator and the stack contents.
  assign softReq = deviceReset;

  always_comb begin
    next_acc = accLoad ? accIn : acc;
    next_ptr[0] = ptr[0];
    next_ptr[1] = ptr[1];
    next_sp = sp;
    next_pc = programCounter;
    next_memWrite = 1'b0;
    next_memAddr = memAddr;
    next_memData = memData;
    next_presc = prescalerConfig;
    next_irq = irqControlReg;
    next_ri = softResetIndicator;
    next_devRst = 1'b0;
    next_state = state;
    next_retCount = retCount;
    next_opReady = opReady;
    pushEn = stackPush;
    next_pushSlot = pushAddr;
    if (stackPush) begin
      next_sp = sp + cmre_pkg::SP_ONE;
    end
    case (state)
      cmre_pkg::CMRE_RUN: begin
        if (opValid && opReady) begin
          next_pc = programCounter + cmre_pkg::PC_ONE;
          case (opCode)
            cmre_pkg::OP_STORE_FILE: begin
              next_memWrite = 1'b1;
              next_memAddr = {{(cmre_pkg::PTR_W-cmre_pkg::FADDR_W){1'b0}}, fileAddr};
              next_memData = acc;
            end
            cmre_pkg::OP_STORE_IND, cmre_pkg::OP_STORE_REL: begin
              // The indirect port has no storage; the write lands at the pointed address.
              next_memWrite = 1'b1;
              next_memAddr = effAddr;
              next_memData = acc;
              next_ptr[ptrSel] = ptrUpd;
            end
            cmre_pkg::OP_LOAD_PRESCALER: begin
              next_presc = acc;
            end
            cmre_pkg::OP_SOFT_RESET: begin
              next_ri = 1'b0;
              next_devRst = 1'b1;
              next_opReady = 1'b0;
            end
            cmre_pkg::OP_RETURN_IRQ: begin
              next_pc = stack[sp];
              next_sp = sp - cmre_pkg::SP_ONE;
              next_irq[cmre_pkg::GIE_BIT] = 1'b1;
              next_state = cmre_pkg::CMRE_RET2;
              next_retCount = cmre_pkg::RETURN_CYCLES - 2'h1;
              next_opReady = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      cmre_pkg::CMRE_RET2: begin
        // Second cycle of the return: the fetched word is discarded.
        next_retCount = retCount - 2'h1;
        if (retCount == 2'h1) begin
          next_state = cmre_pkg::CMRE_RUN;
          next_opReady = 1'b1;
        end
      end
      default: begin
        next_state = cmre_pkg::CMRE_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softReq) begin
      // Status flags are never written here, so they hold zero.
      acc <= cmre_pkg::ACC_RESET;
      ptr[0] <= cmre_pkg::PTR_RESET;
      ptr[1] <= cmre_pkg::PTR_RESET;
      sp <= cmre_pkg::SP_RESET;
      programCounter <= cmre_pkg::PC_RESET;
      memWrite <= 1'b0;
      memAddr <= cmre_pkg::PTR_RESET;
      memData <= cmre_pkg::ACC_RESET;
      prescalerConfig <= cmre_pkg::PRESCALER_RESET;
      irqControlReg <= cmre_pkg::IRQ_CTRL_RESET;
      state <= cmre_pkg::CMRE_RUN;
      retCount <= 2'h0;
      opReady <= 1'b1;
      deviceReset <= 1'b0;
    end else begin
      acc <= next_acc;
      ptr[0] <= next_ptr[0];
      ptr[1] <= next_ptr[1];
      sp <= next_sp;
      programCounter <= next_pc;
      memWrite <= next_memWrite;
      memAddr <= next_memAddr;
      memData <= next_memData;
      prescalerConfig <= next_presc;
      irqControlReg <= next_irq;
      state <= next_state;
      retCount <= next_retCount;
      opReady <= next_opReady;
      deviceReset <= next_devRst;
    end
  end

  // The indicator survives the software reset so the cause can be read back; only rst_n sets it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      softResetIndicator <= 1'b1;
    end else begin
      softResetIndicator <= next_ri;
    end
  end

  // Stack contents are not reset; an unbalanced return reads whatever was left.
  always_ff @(posedge sys_clk) begin
    if (pushEn) begin
      stack[sp + cmre_pkg::SP_ONE] <= next_pushSlot;
    end
  end

  // The mirrors take the software reset on the same edge as the pointers; stackTopEntry then shows PC_RESET for one cycle, not the unreset stack word.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softReq) begin
      stackTopEntry <= cmre_pkg::PC_RESET;
      indirectPointer0 <= cmre_pkg::PTR_RESET;
      indirectPointer1 <= cmre_pkg::PTR_RESET;
      statusFlags <= 3'h0;
    end else begin
      stackTopEntry <= pushEn ? next_pushSlot : stack[next_sp];
      indirectPointer0 <= next_ptr[0];
      indirectPointer1 <= next_ptr[1];
      statusFlags <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> logic/cmre_pkg.sv
// Package for the move/return execution block: operation codes, widths, reset values and bit positions.
// Assumes a single 25 MHz instruction clock and a synchronous active-low reset.
`default_nettype none
package cmre_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PTR_W = 16;
  localparam int OFS_W = 6;
  localparam int PC_W = 11;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W = 4;
  // Operation select presented with opValid.
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_STORE_FILE = 3'h1;
  localparam logic [2:0] OP_STORE_IND = 3'h2;
  localparam logic [2:0] OP_STORE_REL = 3'h3;
  localparam logic [2:0] OP_LOAD_PRESCALER = 3'h4;
  localparam logic [2:0] OP_SOFT_RESET = 3'h5;
  localparam logic [2:0] OP_RETURN_IRQ = 3'h6;
  // Pointer update modes.
  localparam logic [1:0] MODE_PREINC = 2'h0;
  localparam logic [1:0] MODE_PREDEC = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_POSTDEC = 2'h3;
  localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PRESCALER_RESET = 8'hff;
  localparam logic [DATA_W-1:0] IRQ_CTRL_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_ONE = 11'h001;
  localparam logic [SP_W-1:0] SP_ONE = 4'h1;
  localparam logic [SP_W-1:0] SP_RESET = 4'hf;
  localparam int GIE_BIT = 7;
  // Cycles a return from interrupt occupies.
  localparam logic [1:0] RETURN_CYCLES = 2'h2;
  typedef enum logic [1:0] {
    CMRE_RUN = 2'b01,
    CMRE_RET2 = 2'b10
  } cmre_state_t;
endpackage
`default_nettype wire

// >>> logic/cmre_ptr_unit.sv
// Indirect pointer address/update calculator for one store.
// Purely combinational; the caller registers the new pointer.
`default_nettype none
module cmre_ptr_unit (
  // Inputs
  input wire logic [cmre_pkg::PTR_W-1:0] ptrIn,
  input wire logic [1:0] updateMode,
  input wire logic relative,
  input wire logic [cmre_pkg::OFS_W-1:0] offset,
  // Results
  output logic [cmre_pkg::PTR_W-1:0] effAddr,
  output logic [cmre_pkg::PTR_W-1:0] ptrOut
);
  logic [cmre_pkg::PTR_W-1:0] plusOne;
  logic [cmre_pkg::PTR_W-1:0] minusOne;
  logic [cmre_pkg::PTR_W-1:0] ofsExt;

  always_comb begin
    // Modular 16-bit arithmetic wraps at both ends.
    plusOne = ptrIn + cmre_pkg::PTR_ONE;
    minusOne = ptrIn - cmre_pkg::PTR_ONE;
    ofsExt = {{(cmre_pkg::PTR_W-cmre_pkg::OFS_W){offset[cmre_pkg::OFS_W-1]}}, offset};
    effAddr = ptrIn;
    ptrOut = ptrIn;
    if (relative) begin
      effAddr = ptrIn + ofsExt;
    end else begin
      case (updateMode)
        cmre_pkg::MODE_PREINC: begin
          effAddr = plusOne;
          ptrOut = plusOne;
        end
        cmre_pkg::MODE_PREDEC: begin
          effAddr = minusOne;
          ptrOut = minusOne;
        end
        cmre_pkg::MODE_POSTINC: begin
          ptrOut = plusOne;
        end
        default: begin
          ptrOut = minusOne;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/cmre_monitor.sv
// Checker for the move/return execution unit.
// Bound to cmre_core and sees only its ports.
`default_nettype none
module cmre_monitor (
  // Clock, reset, request
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire logic [2:0] opCode,
  input wire logic [6:0] fileAddr,
  // Results
  input wire logic opReady,
  input wire logic memWrite,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] indirectPointer0,
  input wire logic [7:0] prescalerConfig,
  input wire logic [7:0] irqControlReg,
  input wire logic [10:0] programCounter,
  input wire logic [10:0] stackTopEntry,
  input wire logic softResetIndicator,
  input wire logic [2:0] statusFlags,
  input wire logic deviceReset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic take = opValid && opReady;
  sequence retDone;
    irqControlReg[7] && !opReady ##1 opReady;
  endsequence
  sequence resetDone;
    deviceReset && !opReady ##1 !softResetIndicator && programCounter == 11'h000;
  endsequence
  flags_zero_a: assert property (statusFlags == 3'h0) else $error("flags moved");
  file_store_a: assert property (take && opCode == 3'h1 |=> memWrite && memAddr[6:0] == $past(fileAddr))
    else $error("file store wrong");
  ret_pop_a: assert property (take && opCode == 3'h6 |=> programCounter == $past(stackTopEntry) ##0 retDone)
    else $error("return wrong");
  ret_len_a: assert property (take && opCode == 3'h6 |=> !opReady ##1 opReady) else $error("return length");
  soft_reset_a: assert property (take && opCode == 3'h5 |=> resetDone) else $error("soft reset wrong");
  nop_pc_a: assert property (take && opCode == 3'h0 |=> !memWrite && programCounter == $past(programCounter) + 11'h1)
    else $error("nop wrong");
  write_cause_a: assert property (memWrite |-> $past(take && opCode inside {3'h1, 3'h2, 3'h3}))
    else $error("stray write");
  presc_cause_a: assert property ($changed(prescalerConfig) |-> $past(take && opCode == 3'h4) || $past(deviceReset))
    else $error("prescaler changed");
  ptr_step_a: assert property ($changed(indirectPointer0) && !$past(deviceReset) |->
    indirectPointer0 == $past(indirectPointer0) + 16'h1 || indirectPointer0 == $past(indirectPointer0) - 16'h1)
    else $error("pointer step");
endmodule
bind cmre_core cmre_monitor i_cmre_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
  .fileAddr(fileAddr), .opReady(opReady), .memWrite(memWrite), .memAddr(memAddr), .indirectPointer0(indirectPointer0),
  .prescalerConfig(prescalerConfig), .irqControlReg(irqControlReg), .programCounter(programCounter),
  .stackTopEntry(stackTopEntry), .softResetIndicator(softResetIndicator), .statusFlags(statusFlags),
  .deviceReset(deviceReset));
`default_nettype wire

// >>> tb/cpu_move_return_exec_tb.sv
// Self-checking bench for cmre_core.
// Drives inputs at the falling edge and checks at the next falling edge.
`default_nettype none
module cpu_move_return_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, opValid = 0, ptrSel = 0, accLoad = 0, stackPush = 0, opReady, memWrite;
  logic [2:0] opCode = 0, statusFlags;
  logic [6:0] fileAddr = 0;
  logic [1:0] pointerUpdateMode = 0;
  logic [5:0] relOffset = 0;
  logic [7:0] accIn = 0, prescalerConfig, irqControlReg;
  logic [10:0] pushAddr = 0, programCounter, stackTopEntry;
  logic [15:0] memAddr, p0, p1;
  logic [7:0] memData;
  logic softResetIndicator, deviceReset;
  int err_count = 0, n_tests = 0;
  cmre_core i_cmre_core (.sys_clk(sys_clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode), .fileAddr(fileAddr),
    .ptrSel(ptrSel), .pointerUpdateMode(pointerUpdateMode), .relOffset(relOffset), .accLoad(accLoad), .accIn(accIn),
    .stackPush(stackPush), .pushAddr(pushAddr), .opReady(opReady), .memWrite(memWrite), .memAddr(memAddr),
    .memData(memData), .indirectPointer0(p0), .indirectPointer1(p1), .prescalerConfig(prescalerConfig),
    .irqControlReg(irqControlReg), .programCounter(programCounter), .stackTopEntry(stackTopEntry),
    .softResetIndicator(softResetIndicator), .statusFlags(statusFlags), .deviceReset(deviceReset));
  initial forever #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Issues one operation; a stalled unit is waited for, but never for ever.
  task automatic go(input logic [2:0] c);
    int n;
    n = 0;
    // One idle edge keeps opValid from being lowered and raised in one time step.
    @(negedge sys_clk);
    while (opReady !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 10) begin
      err_count++;
      test_done();
    end
    opCode = c;
    opValid = 1'b1;
    @(negedge sys_clk);
    opValid = 1'b0;
  endtask
  task automatic ld(input logic [7:0] v);
    accIn = v;
    accLoad = 1'b1;
    @(negedge sys_clk);
    accLoad = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_file();
    ld(8'h4f);
    fileAddr = 7'h7f;
    go(3'h1);
    chk("file write", {memWrite, memData}, 9'h14f);
    chk("file addr", memAddr, 16'h007f);
    go(3'h4);
    chk("prescaler", prescalerConfig, 8'h4f);
  endtask
  task automatic t_ind();
    logic [1:0] md [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    logic [15:0] ea [4] = '{16'hffff, 16'hffff, 16'h0001, 16'h0001};
    logic [15:0] ep [4] = '{16'hffff, 16'h0000, 16'h0001, 16'h0000};
    ld(8'ha5);
    for (int i = 0; i < 4; i++) begin
      pointerUpdateMode = md[i];
      go(3'h2);
      chk("ind addr", memAddr, ea[i]);
      chk("ind ptr", p0, ep[i]);
      chk("ind data", {memWrite, memData, statusFlags}, 12'hd28);
    end
    chk("other ptr", p1, 16'h0000);
    ptrSel = 1'b1;
    pointerUpdateMode = 2'h0;
    go(3'h2);
    chk("ptr1", p1, 16'h0001);
    relOffset = 6'h20;
    go(3'h3);
    chk("rel low", memAddr, 16'hffe1);
    relOffset = 6'h1f;
    go(3'h3);
    chk("rel high", memAddr, 16'h0020);
    chk("rel ptr", p1, 16'h0001);
  endtask
  task automatic t_nop();
    logic [10:0] pc;
    pc = programCounter;
    go(3'h0);
    chk("nop pc", programCounter, pc + 11'h1);
    chk("nop write", memWrite, 1'b0);
    chk("nop ptr", p1, 16'h0001);
  endtask
  task automatic t_ret();
    pushAddr = 11'h123;
    stackPush = 1'b1;
    @(negedge sys_clk);
    stackPush = 1'b0;
    go(3'h6);
    chk("ret pc", programCounter, 11'h123);
    chk("ret gie", {irqControlReg[7], opReady}, 2'h2);
    @(negedge sys_clk);
    chk("ret done", opReady, 1'b1);
  endtask
  task automatic t_soft();
    go(3'h5);
    chk("soft pulse", deviceReset, 1'b1);
    @(negedge sys_clk);
    chk("soft ind", {softResetIndicator, prescalerConfig, irqControlReg}, 17'h0ff00);
    chk("soft pc", programCounter, 11'h000);
    chk("soft ptr", p1, 16'h0000);
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    chk("reset ind", {softResetIndicator, prescalerConfig}, 9'h1ff);
    t_file();
    t_ind();
    t_nop();
    t_ret();
    t_soft();
    test_done();
  end
endmodule
`default_nettype wire
